// ---- verilog/nvm_ctrl_pkg.sv ----
// Purpose: Constants for the nonvolatile memory program/erase controller
// Assumes: 32-bit Avalon-MM register bus, 50 MHz clock
// Notes:   Register offsets are byte addresses of aligned words
`default_nettype none
package nvm_ctrl_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_DATA_LOW  = 5'h00;
    localparam logic [4:0] OFS_DATA_HIGH = 5'h04;
    localparam logic [4:0] OFS_ADDR_LOW  = 5'h08;
    localparam logic [4:0] OFS_ADDR_HIGH = 5'h0c;
    localparam logic [4:0] OFS_CONTROL   = 5'h10;
    localparam logic [4:0] OFS_UNLOCK    = 5'h14;
    localparam logic [4:0] OFS_PROTECT   = 5'h18;
    localparam int ADDR_W = 5;
    // ----------------------------------------------------------------
    // Control register bits
    // ----------------------------------------------------------------
    localparam int BIT_READ   = 0;
    localparam int BIT_WRITE  = 1;
    localparam int BIT_PGMEN  = 2;
    localparam int BIT_ERROR  = 3;
    localparam int BIT_ERASE  = 4;
    localparam int BIT_LATCH  = 5;
    localparam int BIT_REGION = 6;
    // ----------------------------------------------------------------
    // Values and geometry
    // ----------------------------------------------------------------
    localparam logic [7:0]  KEY_FIRST  = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'haa;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    localparam logic [7:0]  BLANK_BYTE = 8'hff;
    localparam int ROW_WORDS = 32;
    localparam int ROW_BITS  = 5;
    localparam int PGM_WORDS = 16384;
    localparam int EE_BYTES  = 256;
    // Auxiliary region address windows (15-bit address)
    localparam logic [14:0] UID_LO  = 15'h0000;
    localparam logic [14:0] UID_HI  = 15'h0003;
    localparam logic [14:0] ID_LO   = 15'h0005;
    localparam logic [14:0] ID_HI   = 15'h0006;
    localparam logic [14:0] CFG_LO  = 15'h0007;
    localparam logic [14:0] CFG_HI  = 15'h000a;
    localparam logic [14:0] EE_LO   = 15'h7000;
    localparam logic [14:0] EE_HI   = 15'h70ff;
    // ----------------------------------------------------------------
    // Self-timed operation length
    // ----------------------------------------------------------------
    localparam int CLK_HZ     = 50_000_000;
    localparam int OP_TIME_US = 20;
    localparam int OP_CYCLES  = OP_TIME_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        ACC_NONE, ACC_PGM, ACC_AUX, ACC_EE
    } access_t;
endpackage
`default_nettype wire

// ---- verilog/nvm_program_erase_control.sv ----
// Purpose: Self-programming controller for program flash, aux words, EEPROM
// Assumes: Avalon-MM slave, 32-bit data, arrays held inside this block
// Notes:   Write/erase are self-timed; a bus read of any register is
//          answered one cycle after it is taken
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module nvm_program_erase_control
    import nvm_ctrl_pkg::*;
#(
    parameter int OP_WAIT = OP_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [nvm_ctrl_pkg::ADDR_W-1:0] address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [31:0]                 writedata,
    input  wire logic [3:0]                  byteenable,
    output logic      [31:0]                 readdata,
    output logic                             waitrequest,
    output logic                             busy
);
    import nvm_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [13:0] pgmMem   [PGM_WORDS];
    logic [13:0] auxMem   [CFG_HI + 15'h0001];
    logic [7:0]  eeMem    [EE_BYTES];
    logic [13:0] latchMem [ROW_WORDS];

    logic [7:0]  dataLow_r, dataHigh_r, addrLow_r, addrHigh_r;
    logic        region_r, latchOnly_r, erase_r, pgmEnable_r;
    logic        writeErr_r, writeBusy_r, readReq_r;
    logic [1:0]  unlock_r;
    logic        protectAll_r;
    logic [31:0] opCount_r;
    logic        ack_r;
    logic [31:0] readdata_nxt;

    typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_EEWR, OP_AUXWR} opkind_t;
    opkind_t opKind_r;

    logic [14:0] fullAddr;
    logic        busWr, busRd, ctlWr;
    logic        startReq, keyBroken;
    logic [4:0]  rowIdx;

    assign fullAddr = {addrHigh_r[6:0], addrLow_r};
    assign rowIdx   = addrLow_r[ROW_BITS-1:0];
    assign busWr = write && !ack_r;
    assign busRd = read && !ack_r;
    assign ctlWr = busWr && address == OFS_CONTROL && byteenable[0];
    assign startReq = ctlWr && writedata[BIT_WRITE] && !writeBusy_r
                      && unlock_r == 2'd2 && pgmEnable_r;
    // Any control write or stray key write ends a partial unlock
    assign keyBroken = unlock_r != 2'd0 && busWr && byteenable[0]
                       && (address == OFS_CONTROL ? !writedata[BIT_WRITE]
                       : address != OFS_UNLOCK);

    // Classify the current address in the selected region
    function automatic access_t classify(input logic reg1,
                                         input logic [14:0] a,
                                         input logic forWrite);
        if (!reg1) begin
            classify = ACC_PGM;
        end else if (a >= EE_LO && a <= EE_HI) begin
            classify = ACC_EE;
        end else if (a >= UID_LO && a <= UID_HI) begin
            classify = ACC_AUX;
        end else if (!forWrite && a >= ID_LO && a <= CFG_HI) begin
            classify = ACC_AUX;
        end else begin
            classify = ACC_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // Avalon-MM handshake: one wait cycle, answer on the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read || write) && !ack_r;
        end
    end
    assign waitrequest = (read || write) && !ack_r;
    assign busy = writeBusy_r;

    always_comb begin
        readdata_nxt = 32'h0000_0000;
        case (address)
            OFS_DATA_LOW:  readdata_nxt[7:0] = dataLow_r;
            OFS_DATA_HIGH: readdata_nxt[5:0] = dataHigh_r[5:0];
            OFS_ADDR_LOW:  readdata_nxt[7:0] = addrLow_r;
            OFS_ADDR_HIGH: readdata_nxt[7:0] = {1'b1, addrHigh_r[6:0]};
            OFS_CONTROL: begin
                readdata_nxt[BIT_READ]   = readReq_r;
                readdata_nxt[BIT_WRITE]  = writeBusy_r;
                readdata_nxt[BIT_PGMEN]  = pgmEnable_r;
                readdata_nxt[BIT_ERROR]  = writeErr_r;
                readdata_nxt[BIT_ERASE]  = erase_r;
                readdata_nxt[BIT_LATCH]  = latchOnly_r;
                readdata_nxt[BIT_REGION] = region_r;
            end
            OFS_PROTECT:   readdata_nxt[0] = protectAll_r;
            default:       readdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (busRd) begin
            readdata <= readdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Address and mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            addrLow_r  <= 8'h00;
            addrHigh_r <= 8'h00;
        end else if (busWr && byteenable[0]) begin
            if (address == OFS_ADDR_LOW) begin
                addrLow_r <= writedata[7:0];
            end
            if (address == OFS_ADDR_HIGH) begin
                addrHigh_r <= {1'b0, writedata[6:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            region_r    <= 1'b0;
            latchOnly_r <= 1'b0;
            erase_r     <= 1'b0;
            pgmEnable_r <= 1'b0;
            protectAll_r <= 1'b0;
        end else begin
            if (ctlWr) begin
                region_r    <= writedata[BIT_REGION];
                latchOnly_r <= writedata[BIT_LATCH];
                erase_r     <= writedata[BIT_ERASE];
                pgmEnable_r <= writedata[BIT_PGMEN];
            end
            // Write protection is a software-set level here
            if (busWr && address == OFS_PROTECT && byteenable[0]) begin
                protectAll_r <= writedata[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Unlock key tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            unlock_r <= 2'd0;
        end else if (busWr && address == OFS_UNLOCK && byteenable[0]) begin
            if (writedata[7:0] == KEY_FIRST) begin
                unlock_r <= 2'd1;
            end else if (writedata[7:0] == KEY_SECOND
                         && unlock_r == 2'd1) begin
                unlock_r <= 2'd2;
            end else begin
                unlock_r <= 2'd0;
            end
        end else if (ctlWr || keyBroken) begin
            // A broken sequence must start over, or every later write
            // would flag the error again
            unlock_r <= 2'd0;
        end
    end

    // ----------------------------------------------------------------
    // Write/erase sequencer
    // ----------------------------------------------------------------
    logic protHit, latchLoad;
    access_t wrClass;
    assign wrClass   = classify(region_r, fullAddr, 1'b1);
    assign latchLoad = !writedata[BIT_ERASE] && writedata[BIT_LATCH]
                       && !writedata[BIT_REGION];
    assign protHit = !latchLoad && (wrClass == ACC_NONE
                     || (wrClass == ACC_PGM && protectAll_r));

    always_ff @(posedge clk) begin
        if (rst) begin
            writeBusy_r <= 1'b0;
            opCount_r   <= 32'd0;
            opKind_r    <= OP_PROG;
        end else if (writeBusy_r) begin
            if (opCount_r == 32'd0) begin
                writeBusy_r <= 1'b0;
            end else begin
                opCount_r <= opCount_r - 32'd1;
            end
        end else if (startReq && !protHit && !latchLoad) begin
            writeBusy_r <= 1'b1;
            opCount_r   <= 32'(OP_WAIT - 1);
            if (wrClass == ACC_EE) begin
                opKind_r <= OP_EEWR;
            end else if (wrClass == ACC_AUX) begin
                opKind_r <= OP_AUXWR;
            end else if (writedata[BIT_ERASE]) begin
                opKind_r <= OP_ERASE;
            end else begin
                opKind_r <= OP_PROG;
            end
        end
        // Protected start never sets the busy bit
    end

    // Array update at the end of the self-timed wait
    logic opDone;
    // A reset on the final edge aborts the update; arrays keep old data
    assign opDone = writeBusy_r && opCount_r == 32'd0 && !rst;
    logic [8:0] rowBase;
    assign rowBase = fullAddr[13:ROW_BITS];

    always_ff @(posedge clk) begin
        if (opDone) begin
            case (opKind_r)
                OP_PROG: begin
                    for (int i = 0; i < ROW_WORDS; i++) begin
                        pgmMem[{rowBase, 5'(i)}] <= latchMem[i];
                    end
                end
                OP_ERASE: begin
                    for (int i = 0; i < ROW_WORDS; i++) begin
                        pgmMem[{rowBase, 5'(i)}] <= BLANK_WORD;
                    end
                end
                OP_EEWR: eeMem[fullAddr[7:0]] <= dataLow_r;
                OP_AUXWR: auxMem[fullAddr[3:0]] <= {dataHigh_r[5:0],
                                                    dataLow_r};
                default: ;
            endcase
        end
    end

    // Row latches: load on unlocked latch-only start, blank after op
    always_ff @(posedge clk) begin
        if (rst || opDone) begin
            for (int i = 0; i < ROW_WORDS; i++) begin
                latchMem[i] <= BLANK_WORD;
            end
        end else if (startReq && latchLoad) begin
            latchMem[rowIdx] <= {dataHigh_r[5:0], dataLow_r};
        end
    end

    // ----------------------------------------------------------------
    // Error flag: set wins over software clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        // Busy drops on the first reset edge, so only a one-edge reset
        // keeps the abort visible; longer ones clear power-up garbage
        if (rst) begin
            writeErr_r <= writeBusy_r;
        end else if (startReq && protHit) begin
            writeErr_r <= 1'b1;
        end else if (keyBroken) begin
            writeErr_r <= 1'b1;
        end else if (ctlWr) begin
            writeErr_r <= writedata[BIT_ERROR];
        end
    end

    // ----------------------------------------------------------------
    // Read and data registers
    // ----------------------------------------------------------------
    access_t rdClass;
    assign rdClass = classify(region_r, fullAddr, 1'b0);

    always_ff @(posedge clk) begin
        if (rst) begin
            readReq_r <= 1'b0;
        end else begin
            readReq_r <= ctlWr && writedata[BIT_READ] && !readReq_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataLow_r  <= 8'h00;
            dataHigh_r <= 8'h00;
        end else if (readReq_r) begin
            case (rdClass)
                ACC_PGM: {dataHigh_r, dataLow_r} <=
                    {2'b00, pgmMem[fullAddr[13:0]]};
                ACC_AUX: {dataHigh_r, dataLow_r} <=
                    {2'b00, auxMem[fullAddr[3:0]]};
                ACC_EE: dataLow_r <= eeMem[fullAddr[7:0]];
                default: begin
                    dataLow_r  <= 8'h00;
                    dataHigh_r <= 8'h00;
                end
            endcase
        end else if (busWr && byteenable[0]) begin
            if (address == OFS_DATA_LOW) begin
                dataLow_r <= writedata[7:0];
            end
            if (address == OFS_DATA_HIGH) begin
                dataHigh_r <= {2'b00, writedata[5:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_prot_no_busy: assert property (@(posedge clk) disable iff (rst)
        startReq && protHit |=> !writeBusy_r && writeErr_r)
        else $error("Protected start did not flag error");
    a_err_sticky: assert property (@(posedge clk) disable iff (rst)
        writeErr_r && !ctlWr |=> writeErr_r)
        else $error("Error flag cleared by hardware");
    a_read_clears: assert property (@(posedge clk) disable iff (rst)
        readReq_r |=> !readReq_r)
        else $error("Read start did not self-clear");
    a_busy_ends: assert property (@(posedge clk) disable iff (rst)
        opDone |=> !writeBusy_r)
        else $error("Operation did not end");
    a_bad_read_zero: assert property (@(posedge clk) disable iff (rst)
        readReq_r && rdClass == ACC_NONE |=>
        dataLow_r == 8'h00 && dataHigh_r == 8'h00)
        else $error("Unreadable address did not clear data");
    a_high_top_zero: assert property (@(posedge clk) disable iff (rst)
        dataHigh_r[7:6] == 2'b00)
        else $error("High data top bits set");
    a_key_break: assert property (@(posedge clk) disable iff (rst)
        keyBroken |=> writeErr_r)
        else $error("Broken unlock not flagged");
    a_latch_blank: assert property (@(posedge clk) disable iff (rst)
        opDone |=> latchMem[0] == BLANK_WORD)
        else $error("Latch not blank after operation");
    a_reset_abort: assert property (@(posedge clk)
        rst && writeBusy_r |=> writeErr_r)
        else $error("Reset during operation not flagged");
    a_unlock_cancel: assert property (@(posedge clk)
        disable iff (rst) keyBroken |=> unlock_r == 2'd0)
        else $error("Broken unlock left partly open");
endmodule
`default_nettype wire

// ---- test/nvm_host_model.sv ----
// Purpose: Bus master model standing in for the CPU
// Assumes: Avalon-MM slave with waitrequest, one clock
// Notes:   Assumes no wait count; the bench watchdog ends a hang
`default_nettype none
module nvm_host_model
    import nvm_ctrl_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic [31:0]                     readdata,
    input  wire logic                            waitrequest,
    output logic      [nvm_ctrl_pkg::ADDR_W-1:0] address,
    output logic                                 read,
    output logic                                 write,
    output logic      [31:0]                     writedata,
    output logic      [3:0]                      byteenable
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        address    = '0;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'h0;
    end

    // ------
    // One transfer, held until waitrequest is sampled low
    // ------
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic rd,
                        input logic [7:0] d, output logic [31:0] q);
        address    <= a;
        read       <= rd;
        write      <= !rd;
        writedata  <= {24'h00, d};
        byteenable <= 4'hf;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // Idle edge, so a following request never rises in this step
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- test/nvm_program_erase_control_tb.sv ----
// Purpose: Self-checking bench for the program/erase controller
// Assumes: OP_WAIT shortened to 4; rows trusted only after an erase
// Notes:   Each scenario is one task that judges its own results
`default_nettype none
module nvm_program_erase_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_ctrl_pkg::*;

    localparam logic [7:0] C_RD  = 8'(1 << BIT_READ);
    localparam logic [7:0] C_WR  = 8'(1 << BIT_WRITE);
    localparam logic [7:0] C_EN  = 8'(1 << BIT_PGMEN);
    localparam logic [7:0] C_ERR = 8'(1 << BIT_ERROR);
    localparam logic [7:0] C_ER  = 8'(1 << BIT_ERASE);
    localparam logic [7:0] C_LO  = 8'(1 << BIT_LATCH);
    localparam logic [7:0] C_RG  = 8'(1 << BIT_REGION);

    logic              clk;
    logic              rst;
    logic              read;
    logic              write;
    logic              waitrequest;
    logic              busy;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [31:0]       readdata;
    logic [3:0]        byteenable;
    logic [31:0]       q;
    logic [13:0]       w;
    int                c;
    int                miscompares = 0;
    int                nTests = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    nvm_program_erase_control #(.OP_WAIT(4)) uut (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .busy(busy));

    nvm_host_model host (
        .clk(clk), .readdata(readdata), .waitrequest(waitrequest),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));

    // ------
    // Shared helpers
    // ------
    task automatic summarize();
        $display("checks %0d, mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        nTests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            miscompares++;
        end
    endtask

    task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
        logic [31:0] x;
        host.xfer(a, 1'b0, d, x);
    endtask

    task automatic rd(logic [ADDR_W-1:0] a);
        host.xfer(a, 1'b1, 8'h00, q);
    endtask

    task automatic setA(logic [7:0] h, logic [7:0] l);
        wr(OFS_ADDR_HIGH, h);
        wr(OFS_ADDR_LOW, l);
    endtask

    task automatic setD(logic [7:0] h, logic [7:0] l);
        wr(OFS_DATA_HIGH, h);
        wr(OFS_DATA_LOW, l);
    endtask

    // Enable and region bits must already stand when the start bit lands;
    // keys must come straight before the start write
    task automatic go(logic [7:0] ctl);
        wr(OFS_CONTROL, ctl);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CONTROL, ctl | C_WR);
        @(posedge clk);
    endtask

    // Counts busy cycles; a stuck busy shows as a mismatch
    task automatic run(logic [7:0] ctl);
        go(ctl);
        for (c = 0; busy !== 1'b0 && c < 100; c++)
            @(posedge clk);
        chk("busy released", 0, 32'(busy));
        rd(OFS_CONTROL);
        chk("start bit cleared", 0, 32'(q[BIT_WRITE]));
    endtask

    task automatic fetch(logic [7:0] rg, logic [7:0] h, logic [7:0] l);
        setA(h, l);
        wr(OFS_CONTROL, rg | C_RD);
        rd(OFS_DATA_LOW);
        w[7:0] = q[7:0];
        rd(OFS_DATA_HIGH);
        w[13:8] = q[5:0];
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        rd(OFS_DATA_LOW);
        chk("data low reset", 0, q);
        rd(OFS_DATA_HIGH);
        chk("data high reset", 0, q);
        rd(OFS_ADDR_LOW);
        chk("addr low reset", 0, q);
        rd(OFS_CONTROL);
        chk("error after reset", 0, 32'(q[BIT_ERROR]));
        wr(OFS_DATA_HIGH, 8'hff);
        rd(OFS_DATA_HIGH);
        chk("data high top bits", 32'h3f, q);
        wr(OFS_DATA_LOW, 8'ha5);
        rd(OFS_DATA_LOW);
        chk("data low rw", 32'ha5, q);
        wr(OFS_ADDR_LOW, 8'h5a);
        rd(OFS_ADDR_LOW);
        chk("addr low rw", 32'h5a, q);
        rd(5'h1c);
        chk("unmapped read", 0, q);
    endtask

    task automatic t_row();
        setA(8'h01, 8'h20);
        run(C_EN | C_ER);
        chk("erase timed", 1, 32'(c > 0));
        fetch(8'h00, 8'h01, 8'h3f);
        chk("erased word", 32'h3fff, 32'(w));
        rd(OFS_CONTROL);
        chk("read bit cleared", 0, 32'(q[BIT_READ]));
        setA(8'h01, 8'h20);
        setD(8'h01, 8'h23);
        run(C_EN | C_LO);
        chk("latch load untimed", 0, 32'(c));
        setA(8'h01, 8'h3f);
        setD(8'h3e, 8'h5a);
        run(C_EN | C_LO);
        setD(8'h00, 8'h00);
        run(C_EN);
        fetch(8'h00, 8'h01, 8'h20);
        chk("row word 0", 32'h0123, 32'(w));
        fetch(8'h00, 8'h01, 8'h3f);
        chk("row word 31", 32'h3e5a, 32'(w));
        fetch(8'h00, 8'h01, 8'h21);
        chk("unloaded word", 32'h3fff, 32'(w));
        setA(8'h01, 8'h40);
        run(C_EN | C_ER | C_LO);
        run(C_EN);
        fetch(8'h00, 8'h01, 8'h40);
        chk("latches blank", 32'h3fff, 32'(w));
    endtask

    task automatic t_prot();
        setA(8'h01, 8'h60);
        run(C_EN | C_ER);
        wr(OFS_PROTECT, 8'h01);
        setA(8'h01, 8'h20);
        run(C_EN | C_ER);
        chk("protected busy", 0, 32'(c));
        rd(OFS_CONTROL);
        chk("protect error", 32'h08, q & 32'h0a);
        fetch(8'h00, 8'h01, 8'h20);
        chk("kept word", 32'h0123, 32'(w));
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_CONTROL);
        chk("error cleared", 0, 32'(q[BIT_ERROR]));
        setA(8'h01, 8'h60);
        setD(8'h00, 8'h11);
        run(C_EN | C_LO);
        rd(OFS_CONTROL);
        chk("latch under protect", 0, 32'(q[BIT_ERROR]));
        wr(OFS_PROTECT, 8'h00);
        run(C_EN);
        fetch(8'h00, 8'h01, 8'h60);
        chk("latch kept", 32'h0011, 32'(w));
    endtask

    task automatic t_aux();
        setA(8'h70, 8'h05);
        setD(8'h3f, 8'h77);
        run(C_RG | C_EN);
        chk("eeprom timed", 1, 32'(c > 0));
        setD(8'h00, 8'h00);
        fetch(C_RG, 8'h70, 8'h05);
        chk("eeprom byte", 32'h77, 32'(w[7:0]));
        setA(8'h00, 8'h02);
        run(C_RG | C_EN);
        rd(OFS_CONTROL);
        chk("user id write", 0, 32'(q[BIT_ERROR]));
        setA(8'h00, 8'h08);
        run(C_RG | C_EN);
        rd(OFS_CONTROL);
        chk("config write", 1, 32'(q[BIT_ERROR]));
        wr(OFS_CONTROL, 8'h00);
        setD(8'h3f, 8'hff);
        fetch(C_RG, 8'h00, 8'h04);
        chk("hole read", 0, 32'(w));
    endtask

    task automatic t_err();
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_DATA_LOW, 8'h00);
        rd(OFS_CONTROL);
        chk("broken unlock", 1, 32'(q[BIT_ERROR]));
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, C_ERR);
        rd(OFS_CONTROL);
        chk("software set", 1, 32'(q[BIT_ERROR]));
        wr(OFS_CONTROL, 8'h00);
        setA(8'h01, 8'h80);
        go(C_EN | C_ER);
        chk("busy running", 1, 32'(busy));
        // One reset edge while busy; a longer reset clears the flag again
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_CONTROL);
        chk("reset in operation", 1, 32'(q[BIT_ERROR]));
    endtask

    initial begin
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_row();
        t_prot();
        t_aux();
        t_err();
        summarize();
    end

    // Whole run needs well under a thousand cycles; this cuts off a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
